// >>> hw/sgc_global_config_regs.sv
// Operation
// - Bit 7 of configuration one locks all pin-function select bits while it is set.
// - The lock bit cannot be cleared by software and returns to 0 only on hardware reset.
// - Bit 6 of configuration one makes the upper pin group act as parallel IRQ inputs.
// - Bits 5-4 select DMA wait states: reserved, two (default), six, twelve.
// - Bits 3-2 select I/O wait states: zero (default), two, six, twelve.
// - The software reset bit always reads 0 and writing 0 to it does nothing.
// - Writing 1 to software reset resets the logical devices and wake-up control, not locks.
// - Global enable at 0 disables all logical devices except wake-up control.
// - Global enable at 1 (default) lets each device follow its own activate bit.
// - Index 20h is a read-only identity register that ignores writes.
// - Pin select bits 7 and 6 choose general I/O or keyboard port bits 17 and 12.
// - Pin select bits 5 to 2 choose general I/O or the four fan functions in order.
// - Pin select bits 1-0 are read-only and read as 00.
`timescale 1ns/1ps
module sgc_global_config_regs
  import sgc_pkg::*;
#(
  parameter int NUM_DEVICES = 8
)
(
  input  wire logic                        CLK_I,
  input  wire logic                        RESET_I,
  input  wire logic [sgc_pkg::ADDR_W-1:0]  ADDR_I,
  input  wire logic [sgc_pkg::DATA_W-1:0]  WDATA_I,
  input  wire logic                        WR_I,
  input  wire logic                        RD_I,
  output logic      [sgc_pkg::DATA_W-1:0]  RDATA_O,
  input  wire logic [NUM_DEVICES-1:0]      DEVICE_ACTIVATE_I,
  output logic      [NUM_DEVICES-1:0]      DEVICE_ENABLE_O,
  output logic                             WAKEUP_ENABLE_O,
  output logic                             DEVICE_SOFT_RESET_O,
  output logic                             WAKEUP_SOFT_RESET_O,
  output logic                             PIN_LOCK_O,
  output logic                             PARALLEL_IRQ_INPUT_SEL_O,
  output logic                             UPPER_GROUP_CFG4_SEL_O,
  output logic      [3:0]                  DMA_WAIT_STATES_O,
  output logic                             DMA_WAIT_RESERVED_O,
  output logic      [3:0]                  IO_WAIT_STATES_O,
  output logic                             KEYBOARD_PORT_BIT_17_SEL_O,
  output logic                             KEYBOARD_PORT_BIT_12_SEL_O,
  output logic                             FAN0_PWM_OUTPUT_SEL_O,
  output logic                             FAN0_TACH_INPUT_SEL_O,
  output logic                             FAN1_PWM_OUTPUT_SEL_O,
  output logic                             FAN1_TACH_INPUT_SEL_O,
  output logic                             GENERAL_IO_PIN_34_SEL_O
);

  localparam int KBD_W  = PS_KBD17_BIT - PS_KBD12_BIT + 1;
  localparam int FAN_W  = PS_FAN_HI - PS_FAN_LO + 1;
  localparam int WAIT_W = CF1_DMA_HI - CF1_DMA_LO + 1;
  localparam logic [3:0] DMA_COUNT_RESET = WAIT_TWO;
  localparam logic [3:0] IO_COUNT_RESET  = WAIT_ZERO;

  // Configuration one fields
  logic                   lock;
  logic                   override_reg;
  logic                   override_next;
  logic [WAIT_W-1:0]      dma_wait_reg;
  logic [WAIT_W-1:0]      dma_wait_next;
  logic [WAIT_W-1:0]      io_wait_reg;
  logic [WAIT_W-1:0]      io_wait_next;
  logic                   global_en_reg;
  logic                   global_en_next;
  // Pin select fields
  logic [KBD_W-1:0]       kbd_sel_reg;
  logic [KBD_W-1:0]       kbd_sel_next;
  logic [FAN_W-1:0]       fan_sel_reg;
  logic [FAN_W-1:0]       fan_sel_next;
  // Registered status outputs
  logic                   cfg4_sel_reg;
  logic                   cfg4_sel_next;
  logic                   dma_rsv_reg;
  logic                   dma_rsv_next;
  logic [3:0]             dma_count_reg;
  logic [3:0]             dma_count_next;
  logic [3:0]             io_count_reg;
  logic [3:0]             io_count_next;
  logic                   swrst_reg;
  logic                   swrst_next;
  // Read path
  logic [DATA_W-1:0]      id_view;
  logic [DATA_W-1:0]      cf1_view;
  logic [DATA_W-1:0]      ps_view;
  logic [DATA_W-1:0]      rdata_reg;
  logic [DATA_W-1:0]      rdata_next;

  // Address decode
  wire                    hit_id      = (ADDR_I == IDX_CHIP_ID);
  wire                    hit_cf1     = (ADDR_I == IDX_CFG_ONE);
  wire                    hit_ps      = (ADDR_I == IDX_PIN_SEL);
  wire                    wr_cf1      = WR_I & hit_cf1;
  wire                    wr_ps       = WR_I & hit_ps;
  wire                    rd_id       = RD_I & hit_id;
  wire                    rd_cf1      = RD_I & hit_cf1;
  wire                    rd_ps       = RD_I & hit_ps;

  // Write data split into fields
  wire                    wd_lock     = WDATA_I[CF1_LOCK_BIT];
  wire                    wd_ovr      = WDATA_I[CF1_OVR_BIT];
  wire [WAIT_W-1:0]       wd_dma      = WDATA_I[CF1_DMA_HI:CF1_DMA_LO];
  wire [WAIT_W-1:0]       wd_io       = WDATA_I[CF1_IO_HI:CF1_IO_LO];
  wire                    wd_swrst    = WDATA_I[CF1_SWRST_BIT];
  wire                    wd_gen      = WDATA_I[CF1_GEN_BIT];
  wire [KBD_W-1:0]        wd_kbd      = WDATA_I[PS_KBD17_BIT:PS_KBD12_BIT];
  wire [FAN_W-1:0]        wd_fan      = WDATA_I[PS_FAN_HI:PS_FAN_LO];

  wire                    lock_set    = wr_cf1 & wd_lock;
  wire                    sel_wr_ok   = ~lock;
  wire                    wr_ovr      = wr_cf1 & sel_wr_ok;
  wire                    wr_pins     = wr_ps & sel_wr_ok;

  // group override is a lockable select
  assign override_next  = wr_ovr ? wd_ovr : override_reg;
  assign cfg4_sel_next  = ~override_next;
  assign dma_wait_next  = wr_cf1 ? wd_dma : dma_wait_reg;
  assign io_wait_next   = wr_cf1 ? wd_io : io_wait_reg;
  assign dma_rsv_next   = (dma_wait_next == WAIT_CODE_0);
  assign global_en_next = wr_cf1 ? wd_gen : global_en_reg;
  assign kbd_sel_next   = wr_pins ? wd_kbd : kbd_sel_reg;
  assign fan_sel_next   = wr_pins ? wd_fan : fan_sel_reg;
  // one-cycle pulse on write of 1
  assign swrst_next     = wr_cf1 & wd_swrst;

  sgc_wait_decode #(.CODE0_COUNT(WAIT_ZERO)) u_dma_wait
  (
    .code_i  (dma_wait_next),
    .count_o (dma_count_next)
  );
  sgc_wait_decode #(.CODE0_COUNT(WAIT_ZERO)) u_io_wait
  (
    .code_i  (io_wait_next),
    .count_o (io_count_next)
  );

  assign cf1_view   = {lock,
                       override_reg,
                       dma_wait_reg,
                       io_wait_reg,
                       1'b0,
                       global_en_reg};
  assign ps_view    = {kbd_sel_reg,
                       fan_sel_reg,
                       PS_RO_FIELD};
  assign id_view    = CHIP_ID_VALUE;
  // Unmapped index and idle cycles read 0
  assign rdata_next = ({DATA_W{rd_id}} & id_view)
                    | ({DATA_W{rd_cf1}} & cf1_view)
                    | ({DATA_W{rd_ps}} & ps_view);

  sgc_lock_bit u_lock
  (
    .CLK_I   (CLK_I),
    .RESET_I (RESET_I),
    .set_i   (lock_set),
    .q_o     (lock)
  );

  always_ff @(posedge CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
      override_reg <= CF1_RESET[CF1_OVR_BIT];
    else
      override_reg <= override_next;
  end

  always_ff @(posedge CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
      cfg4_sel_reg <= ~CF1_RESET[CF1_OVR_BIT];
    else
      cfg4_sel_reg <= cfg4_sel_next;
  end

  always_ff @(posedge CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
      dma_wait_reg <= CF1_RESET[CF1_DMA_HI:CF1_DMA_LO];
    else
      dma_wait_reg <= dma_wait_next;
  end

  always_ff @(posedge CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
      dma_rsv_reg <= (CF1_RESET[CF1_DMA_HI:CF1_DMA_LO] == WAIT_CODE_0);
    else
      dma_rsv_reg <= dma_rsv_next;
  end

  always_ff @(posedge CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
      dma_count_reg <= DMA_COUNT_RESET;
    else
      dma_count_reg <= dma_count_next;
  end

  always_ff @(posedge CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
      io_wait_reg <= CF1_RESET[CF1_IO_HI:CF1_IO_LO];
    else
      io_wait_reg <= io_wait_next;
  end

  always_ff @(posedge CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
      io_count_reg <= IO_COUNT_RESET;
    else
      io_count_reg <= io_count_next;
  end

  always_ff @(posedge CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
      global_en_reg <= CF1_RESET[CF1_GEN_BIT];
    else
      global_en_reg <= global_en_next;
  end

  always_ff @(posedge CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
      kbd_sel_reg <= PS_RESET[PS_KBD17_BIT:PS_KBD12_BIT];
    else
      kbd_sel_reg <= kbd_sel_next;
  end

  always_ff @(posedge CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
      fan_sel_reg <= PS_RESET[PS_FAN_HI:PS_FAN_LO];
    else
      fan_sel_reg <= fan_sel_next;
  end

  always_ff @(posedge CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
      swrst_reg <= 1'b0;
    else
      swrst_reg <= swrst_next;
  end

  always_ff @(posedge CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
      rdata_reg <= '0;
    else
      rdata_reg <= rdata_next;
  end

  assign RDATA_O = rdata_reg;

  // soft reset to devices and wake-up unit
  assign DEVICE_SOFT_RESET_O = swrst_reg;
  assign WAKEUP_SOFT_RESET_O = swrst_reg;

  assign DEVICE_ENABLE_O = global_en_reg ? DEVICE_ACTIVATE_I : '0;
  assign WAKEUP_ENABLE_O = 1'b1;

  assign PIN_LOCK_O               = lock;
  assign PARALLEL_IRQ_INPUT_SEL_O = override_reg;
  assign UPPER_GROUP_CFG4_SEL_O   = cfg4_sel_reg;

  assign DMA_WAIT_STATES_O   = dma_count_reg;
  assign DMA_WAIT_RESERVED_O = dma_rsv_reg;
  assign IO_WAIT_STATES_O    = io_count_reg;

  assign {KEYBOARD_PORT_BIT_17_SEL_O, KEYBOARD_PORT_BIT_12_SEL_O} = kbd_sel_reg;
  assign {FAN0_PWM_OUTPUT_SEL_O, FAN0_TACH_INPUT_SEL_O,
          FAN1_PWM_OUTPUT_SEL_O, FAN1_TACH_INPUT_SEL_O} = fan_sel_reg;
  assign GENERAL_IO_PIN_34_SEL_O    = (PS_RO_FIELD == 2'h0);

endmodule

// >>> hw/sgc_pkg.sv
package sgc_pkg;
  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 8;
  // Register indexes
  localparam logic [7:0]  IDX_CHIP_ID     = 8'h20;
  localparam logic [7:0]  IDX_CFG_ONE     = 8'h21;
  localparam logic [7:0]  IDX_PIN_SEL     = 8'h22;
  // Identity code, value arbitrary
  localparam logic [7:0]  CHIP_ID_VALUE   = 8'h5A;
  // Configuration one fields
  localparam int          CF1_LOCK_BIT    = 7;
  localparam int          CF1_OVR_BIT     = 6;
  localparam int          CF1_DMA_HI      = 5;
  localparam int          CF1_DMA_LO      = 4;
  localparam int          CF1_IO_HI       = 3;
  localparam int          CF1_IO_LO       = 2;
  localparam int          CF1_SWRST_BIT   = 1;
  localparam int          CF1_GEN_BIT     = 0;
  localparam logic [7:0]  CF1_RESET       = 8'h11;
  // Pin select fields
  localparam int          PS_KBD17_BIT    = 7;
  localparam int          PS_KBD12_BIT    = 6;
  localparam int          PS_FAN_HI       = 5;
  localparam int          PS_FAN_LO       = 2;
  localparam logic [7:0]  PS_RESET        = 8'h00;
  localparam logic [1:0]  PS_RO_FIELD     = 2'h0;
  // Wait state codes
  localparam logic [1:0]  WAIT_CODE_0     = 2'h0;
  localparam logic [1:0]  WAIT_CODE_1     = 2'h1;
  localparam logic [1:0]  WAIT_CODE_2     = 2'h2;
  localparam logic [3:0]  WAIT_ZERO       = 4'h0;
  localparam logic [3:0]  WAIT_TWO        = 4'h2;
  localparam logic [3:0]  WAIT_SIX        = 4'h6;
  localparam logic [3:0]  WAIT_TWELVE     = 4'hC;
endpackage

// >>> hw/sgc_lock_bit.sv
`timescale 1ns/1ps
// Sticky set-only bit, cleared by hardware reset only
module sgc_lock_bit
(
  input  wire logic CLK_I,
  input  wire logic RESET_I,
  input  wire logic set_i,
  output logic      q_o
);
  always_ff @(posedge CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
      q_o <= 1'b0;
    else if (set_i)
      q_o <= 1'b1;
  end
endmodule

// >>> hw/sgc_wait_decode.sv
`timescale 1ns/1ps
// Maps a two-bit wait code to a cycle count
module sgc_wait_decode
  import sgc_pkg::*;
#(
  parameter logic [3:0] CODE0_COUNT = WAIT_ZERO
)
(
  input  wire logic [1:0] code_i,
  output logic      [3:0] count_o
);
  assign count_o = (code_i == WAIT_CODE_0) ? CODE0_COUNT :
                   (code_i == WAIT_CODE_1) ? WAIT_TWO :
                   (code_i == WAIT_CODE_2) ? WAIT_SIX : WAIT_TWELVE;
endmodule

// >>> verif/sgc_global_config_regs_chk.sv
`timescale 1ns/1ps
module sgc_global_config_regs_chk
  import sgc_pkg::*;
(
  input wire logic       CLK_I,
  input wire logic       RESET_I,
  input wire logic [7:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic       WR_I,
  input wire logic       RD_I,
  input wire logic [7:0] RDATA_O,
  input wire logic       DEVICE_SOFT_RESET_O,
  input wire logic       PIN_LOCK_O,
  input wire logic       PARALLEL_IRQ_INPUT_SEL_O,
  input wire logic       UPPER_GROUP_CFG4_SEL_O,
  input wire logic       KEYBOARD_PORT_BIT_17_SEL_O,
  input wire logic       FAN1_TACH_INPUT_SEL_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RESET_I);
  sequence swrst_write;
    WR_I && ADDR_I == IDX_CFG_ONE && WDATA_I[CF1_SWRST_BIT];
  endsequence
  sequence swrst_pulse;
    DEVICE_SOFT_RESET_O ##1 (!DEVICE_SOFT_RESET_O ||
      $past(WR_I && ADDR_I == IDX_CFG_ONE && WDATA_I[CF1_SWRST_BIT]));
  endsequence
  AST_SWRST_PULSE: assert property (swrst_write |=> swrst_pulse)
    else $error("soft reset pulse wrong");
  AST_RDATA_IDLE: assert property (!$past(RD_I) |-> RDATA_O == 8'h00)
    else $error("read data not idle");
  AST_ID_READ: assert property (RD_I && ADDR_I == IDX_CHIP_ID |=> RDATA_O == CHIP_ID_VALUE)
    else $error("identity read wrong");
  AST_RO_FIELD: assert property (RD_I && ADDR_I == IDX_PIN_SEL |=> RDATA_O[1:0] == PS_RO_FIELD)
    else $error("pin select low field not zero");
  AST_SWRST_READ: assert property (RD_I && ADDR_I == IDX_CFG_ONE |=> !RDATA_O[1])
    else $error("soft reset bit read as one");
  AST_LOCK_SET: assert property (WR_I && ADDR_I == IDX_CFG_ONE && WDATA_I[CF1_LOCK_BIT] |=> PIN_LOCK_O)
    else $error("lock not set");
  AST_LOCK_STICKY: assert property (PIN_LOCK_O |=> PIN_LOCK_O)
    else $error("lock cleared");
  AST_LOCK_HOLD: assert property (PIN_LOCK_O && WR_I |=> $stable(PARALLEL_IRQ_INPUT_SEL_O) &&
    $stable(KEYBOARD_PORT_BIT_17_SEL_O) && $stable(FAN1_TACH_INPUT_SEL_O))
    else $error("locked select changed");
  AST_OVR_SEL: assert property (UPPER_GROUP_CFG4_SEL_O != PARALLEL_IRQ_INPUT_SEL_O)
    else $error("group override selects disagree");
endmodule
bind sgc_global_config_regs sgc_global_config_regs_chk u_chk (.CLK_I, .RESET_I, .ADDR_I,
  .WDATA_I, .WR_I, .RD_I, .RDATA_O, .DEVICE_SOFT_RESET_O, .PIN_LOCK_O,
  .PARALLEL_IRQ_INPUT_SEL_O, .UPPER_GROUP_CFG4_SEL_O, .KEYBOARD_PORT_BIT_17_SEL_O,
  .FAN1_TACH_INPUT_SEL_O);

// >>> verif/testbench.sv
`timescale 1ns/1ps
module testbench;
  import sgc_pkg::*;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] act = 8'hA5;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  wire  [7:0] rdata, den;
  wire  [3:0] dma, iow;
  wire  [5:0] psel;
  wire        wen, srst, wrst, lock, parallel_irq_input, cfg4, rsv, gio;
  int         num_errors = 0;
  int         check_count = 0;
  always #2 clk = ~clk;
  sgc_global_config_regs dut (.CLK_I(clk), .RESET_I(rst), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .DEVICE_ACTIVATE_I(act), .DEVICE_ENABLE_O(den),
    .WAKEUP_ENABLE_O(wen), .DEVICE_SOFT_RESET_O(srst), .WAKEUP_SOFT_RESET_O(wrst),
    .PIN_LOCK_O(lock), .PARALLEL_IRQ_INPUT_SEL_O(parallel_irq_input), .UPPER_GROUP_CFG4_SEL_O(cfg4),
    .DMA_WAIT_STATES_O(dma), .DMA_WAIT_RESERVED_O(rsv), .IO_WAIT_STATES_O(iow),
    .KEYBOARD_PORT_BIT_17_SEL_O(psel[5]), .KEYBOARD_PORT_BIT_12_SEL_O(psel[4]),
    .FAN0_PWM_OUTPUT_SEL_O(psel[3]), .FAN0_TACH_INPUT_SEL_O(psel[2]),
    .FAN1_PWM_OUTPUT_SEL_O(psel[1]), .FAN1_TACH_INPUT_SEL_O(psel[0]),
    .GENERAL_IO_PIN_34_SEL_O(gio));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask
  task automatic t_waits;
    logic [3:0] cnt [4] = '{4'h0, 4'h2, 4'h6, 4'hC};
    for (int i = 0; i < 4; i++)
    begin
      wrr(8'h21, {2'b00, i[1:0], i[1:0], 2'b01});
      chk({dma, iow}, {cnt[i], cnt[i]});
      chk({7'h0, rsv}, {7'h0, i == 0});
    end
  endtask
  task automatic t_swrst;
    wrr(8'h21, 8'h13);
    chk({6'h0, srst, wrst}, 8'h03);
    @(posedge clk);
    #1;
    chk({6'h0, srst, wrst}, 8'h00);
    rdc(8'h21, 8'h11);
    wrr(8'h21, 8'h11);
    chk({7'h0, srst}, 8'h00);
  endtask
  task automatic t_enable;
    wrr(8'h21, 8'h10);
    chk(den, 8'h00);
    chk({7'h0, wen}, 8'h01);
    wrr(8'h21, 8'h11);
    chk(den, act);
  endtask
  task automatic t_pins;
    wrr(8'h22, 8'hFF);
    rdc(8'h22, 8'hFC);
    chk({2'b00, psel}, 8'h3F);
    chk({7'h0, gio}, 8'h01);
    wrr(8'h21, 8'h51);
    chk({6'h0, parallel_irq_input, cfg4}, 8'h02);
    wrr(8'h20, 8'h00);
    rdc(8'h20, CHIP_ID_VALUE);
    rdc(8'h30, 8'h00);
  endtask
  task automatic t_lock;
    wrr(8'h21, 8'h91);
    wrr(8'h21, 8'h01);
    wrr(8'h22, 8'h00);
    rdc(8'h22, 8'hFC);
    rdc(8'h21, 8'h81);
    wrr(8'h21, 8'h7D);
    rdc(8'h21, 8'hBD);
    chk({6'h0, parallel_irq_input, cfg4}, 8'h01);
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    #1;
    chk({7'h0, lock}, 8'h00);
    rdc(8'h21, CF1_RESET);
    rdc(8'h22, PS_RESET);
  endtask
  task automatic stop_test;
    if (num_errors == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    #20000;
    num_errors++;
    stop_test();
  end
  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rdc(8'h21, CF1_RESET);
    chk(den, act);
    t_waits();
    t_swrst();
    t_enable();
    t_pins();
    t_lock();
    stop_test();
  end
endmodule
